/* File: cmp_ctrl.sv */
// dual comparator control and status: five byte registers, edge events, routing
// assumes single clock, comparator outputs asynchronous, pin levels raw from pads
//
// What this block does
// - first comparator interrupt raised on event only when its enable bit is one.
// - first event flag set on configured edge; stays until software writes zero.
// - each interrupt request is high while its flag and enable are both set.
// - each output status bit mirrors its comparator output, read only.
// - first edge field: 00 off, 01 falling, 10 rising, 11 both.
// - second edge field uses same encoding as the first.
// - second event flag set on configured edge; cleared only by writing zero.
// - second comparator interrupt raised on event only when its enable bit is one.
// - schmitt enable bit affects analogue pins only while their switch is closed.
// - speed bit zero selects slow, one selects fast for second comparator.
// - route field sends second output to t2 cap2, t3 cap2, t1 break, t1 clear.
// - routed capture or break timer input is cut off from its pin.
// - three-bit field selects second comparator inverting input source.
// - reference-connect bit attaches internal reference to first inverting input.
// - window-enable bit pairs both comparators in window mode.
// - reference-output enable drives internal reference onto group 3 pins.
// - group 8 pin triggers: bit one disables, zero enables.
// - group 2 pin triggers: bit one disables, zero enables.
// - group 5 dac pin triggers: bit one disables, zero enables.
// - group 3 reference pin triggers: bit one disables, zero enables.
// - disabled trigger forces that pin's input data bit to zero.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module cmp_ctrl
  import cmp_ctrl_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic CMP1_RAW,
  input wire logic CMP2_RAW,
  input wire logic SW_CLOSED,
  input wire logic [2:0] PIN_G8,
  input wire logic [2:0] PIN_G2,
  input wire logic [2:0] PIN_G5,
  input wire logic [2:0] PIN_G3,
  input wire logic TIM_PIN_CAP2_T2,
  input wire logic TIM_PIN_CAP2_T3,
  input wire logic TIM_PIN_BRK_T1,
  output logic IRQ1,
  output logic IRQ2,
  output logic CMP1_ON,
  output logic CMP2_ON,
  output logic SCHMITT_ACTIVE,
  output logic FAST_MODE,
  output logic REF_TO_CMP1,
  output logic WINDOW_MODE,
  output logic REF_OUT_EN,
  output logic [2:0] INSEL_OUT,
  output logic [2:0] IDR_G8,
  output logic [2:0] IDR_G2,
  output logic [2:0] IDR_G5,
  output logic [2:0] IDR_G3,
  output logic T2_CAP2,
  output logic T3_CAP2,
  output logic T1_BRK,
  output logic T1_CLR
);

  ////////////////////////////////////////////////////////////////////////////
  bus_req_t req;
  cmp_csr_t one_q, two_q;
  route_ref_t route_q;
  trig_t intrig_q, outtrig_q;
  logic [1:0] s1_q, s2_q;
  logic c1_q, c2_q;
  logic ev1, ev2;

  assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  ////////////////////////////////////////////////////////////////////////////
  // two-stage synchronisers, then one more stage for edge history
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      s1_q <= 2'b00;
      s2_q <= 2'b00;
      c1_q <= 1'b0;
      c2_q <= 1'b0;
    end else begin
      s1_q <= {s1_q[0], CMP1_RAW};
      s2_q <= {s2_q[0], CMP2_RAW};
      c1_q <= s1_q[1];
      c2_q <= s2_q[1];
    end
  end

  function automatic logic edge_hit(input edge_mode_t m, input logic now, input logic was);
    logic r;
    r = 1'b0;
    case (m)
      EDGE_FALL: r = was & ~now;
      EDGE_RISE: r = ~was & now;
      EDGE_BOTH: r = was ^ now;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  assign ev1 = edge_hit(one_q.edge_config, s1_q[1], c1_q);
  assign ev2 = edge_hit(two_q.edge_config, s2_q[1], c2_q);

  ////////////////////////////////////////////////////////////////////////////
  // register writes; event set wins over software clear
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      one_q <= cmp_csr_t'(RST_ONE);
      two_q <= cmp_csr_t'(RST_TWO);
      route_q <= route_ref_t'(RST_ROUTE);
      intrig_q <= trig_t'(RST_INTRIG);
      outtrig_q <= trig_t'(RST_OUTTRIG);
    end else begin
      one_q.output_copy <= s1_q[1];
      two_q.output_copy <= s2_q[1];
      if (req.wr && req.addr == OFF_ONE) begin
        one_q.irq_enable <= req.wdata[B_IE];
        one_q.mid_bit <= req.wdata[B_MID];
        one_q.edge_config <= edge_mode_t'(req.wdata[B_EDGE +: 2]);
      end
      if (ev1)
        one_q.event_flag <= 1'b1;
      else if (req.wr && req.addr == OFF_ONE && !req.wdata[B_EF])
        one_q.event_flag <= 1'b0;
      if (req.wr && req.addr == OFF_TWO) begin
        two_q.irq_enable <= req.wdata[B_IE];
        two_q.mid_bit <= req.wdata[B_MID];
        two_q.edge_config <= edge_mode_t'(req.wdata[B_EDGE +: 2]);
      end
      if (ev2)
        two_q.event_flag <= 1'b1;
      else if (req.wr && req.addr == OFF_TWO && !req.wdata[B_EF])
        two_q.event_flag <= 1'b0;
      if (req.wr && req.addr == OFF_ROUTE)
        route_q <= route_ref_t'(req.wdata);
      if (req.wr && req.addr == OFF_INTRIG)
        intrig_q <= trig_t'({2'b00, req.wdata[5:0]});
      if (req.wr && req.addr == OFF_OUTTRIG)
        outtrig_q <= trig_t'({2'b00, req.wdata[5:0]});
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port, data one cycle after the strobe
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      RDATA <= RD_UNMAPPED;
    end else if (req.rd) begin
      if (req.addr == OFF_ONE)
        RDATA <= one_q;
      else if (req.addr == OFF_TWO)
        RDATA <= two_q;
      else if (req.addr == OFF_ROUTE)
        RDATA <= route_q;
      else if (req.addr == OFF_INTRIG)
        RDATA <= intrig_q;
      else if (req.addr == OFF_OUTTRIG)
        RDATA <= outtrig_q;
      else
        RDATA <= RD_UNMAPPED;
    end else begin
      RDATA <= RD_UNMAPPED;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered control outputs to the analogue side and pads
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      IRQ1 <= 1'b0;
      IRQ2 <= 1'b0;
      CMP1_ON <= 1'b0;
      CMP2_ON <= 1'b0;
      SCHMITT_ACTIVE <= 1'b0;
      FAST_MODE <= 1'b0;
      REF_TO_CMP1 <= 1'b0;
      WINDOW_MODE <= 1'b0;
      REF_OUT_EN <= 1'b0;
      INSEL_OUT <= 3'h0;
    end else begin
      IRQ1 <= one_q.event_flag & one_q.irq_enable;
      IRQ2 <= two_q.event_flag & two_q.irq_enable;
      CMP1_ON <= one_q.edge_config != EDGE_OFF;
      CMP2_ON <= two_q.edge_config != EDGE_OFF;
      SCHMITT_ACTIVE <= one_q.mid_bit & SW_CLOSED;
      FAST_MODE <= two_q.mid_bit;
      REF_TO_CMP1 <= route_q.reference_connect;
      WINDOW_MODE <= route_q.window_enable;
      REF_OUT_EN <= route_q.reference_output_enable;
      INSEL_OUT <= route_q.reference_input_select;
    end
  end

  // pin input data: a disabled trigger reads as zero
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      IDR_G8 <= 3'h0;
      IDR_G2 <= 3'h0;
      IDR_G5 <= 3'h0;
      IDR_G3 <= 3'h0;
    end else begin
      IDR_G8 <= PIN_G8 & ~intrig_q.hi_off;
      IDR_G2 <= PIN_G2 & ~intrig_q.lo_off;
      IDR_G5 <= PIN_G5 & ~outtrig_q.hi_off;
      IDR_G3 <= PIN_G3 & ~outtrig_q.lo_off;
    end
  end

  // timer inputs: routed one takes the comparator, unrouted capture and break inputs keep their pin, unrouted clear is zero
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      T2_CAP2 <= 1'b0;
      T3_CAP2 <= 1'b0;
      T1_BRK <= 1'b0;
      T1_CLR <= 1'b0;
    end else begin
      T2_CAP2 <= (route_q.output_route_select == ROUTE_T2_CAP2) ? s2_q[1] :
        TIM_PIN_CAP2_T2;
      T3_CAP2 <= (route_q.output_route_select == ROUTE_T3_CAP2) ? s2_q[1] :
        TIM_PIN_CAP2_T3;
      T1_BRK <= (route_q.output_route_select == ROUTE_T1_BRK) ? s2_q[1] :
        TIM_PIN_BRK_T1;
      T1_CLR <= (route_q.output_route_select == ROUTE_T1_CLR) & s2_q[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_ev1;
    ev1;
  endsequence
  sequence s_ev2;
    ev2;
  endsequence

  AST_EF1_SET: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    s_ev1 |=> one_q.event_flag) else $error("first flag not set on event");
  AST_EF2_SET: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    s_ev2 |=> two_q.event_flag) else $error("second flag not set on event");
  AST_EF1_HOLD: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    one_q.event_flag && !(req.wr && req.addr == OFF_ONE) |=> one_q.event_flag)
    else $error("first flag dropped without write");
  AST_EF2_CLR: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    req.wr && req.addr == OFF_TWO && !req.wdata[B_EF] && !ev2 |=> !two_q.event_flag)
    else $error("second flag not cleared by zero write");
  AST_IRQ1: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    one_q.event_flag && one_q.irq_enable |=> IRQ1) else $error("first irq missing");
  AST_IRQ2_MASK: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    !two_q.irq_enable |=> !IRQ2) else $error("second irq not masked");
  AST_OFF_NO_EV: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    one_q.edge_config == EDGE_OFF |-> !ev1) else $error("event while disabled");
  AST_RISE_ONLY: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    two_q.edge_config == EDGE_RISE && ev2 |-> s2_q[1] && !c2_q)
    else $error("rising mode fired on wrong edge");
  AST_MIRROR: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    ##1 one_q.output_copy == $past(s1_q[1])) else $error("output copy stale");
  AST_IDR_ZERO: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    intrig_q.lo_off[0] |=> !IDR_G2[0]) else $error("disabled pin read nonzero");
  AST_ROUTE_CUT: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    route_q.output_route_select == ROUTE_T1_BRK |=> T1_BRK == $past(s2_q[1]))
    else $error("break input not cut from pin");

  // synchronised comparator level through edge detection into the event flags
  sequence s_rise1;
    !s1_q[1] ##1 s1_q[1];
  endsequence
  sequence s_fall1;
    s1_q[1] ##1 !s1_q[1];
  endsequence
  sequence s_rise2;
    !s2_q[1] ##1 s2_q[1];
  endsequence
  sequence s_fall2;
    s2_q[1] ##1 !s2_q[1];
  endsequence

  AST_SYNC1: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    RST_N |=> s1_q[1] == $past(s1_q[0]) && c1_q == $past(s1_q[1]))
    else $error("first synchroniser chain broken");
  AST_SYNC2: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    RST_N |=> s2_q[1] == $past(s2_q[0]) && c2_q == $past(s2_q[1]))
    else $error("second synchroniser chain broken");
  AST_EF1_RISE: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    s_rise1 ##0 (RST_N && one_q.edge_config inside {EDGE_RISE, EDGE_BOTH}) |=> one_q.event_flag)
    else $error("first flag missed a rising edge");
  AST_EF1_FALL: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    s_fall1 ##0 (RST_N && one_q.edge_config inside {EDGE_FALL, EDGE_BOTH}) |=> one_q.event_flag)
    else $error("first flag missed a falling edge");
  AST_EF2_RISE: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    s_rise2 ##0 (RST_N && two_q.edge_config inside {EDGE_RISE, EDGE_BOTH}) |=> two_q.event_flag)
    else $error("second flag missed a rising edge");
  AST_EF2_FALL: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    s_fall2 ##0 (RST_N && two_q.edge_config inside {EDGE_FALL, EDGE_BOTH}) |=> two_q.event_flag)
    else $error("second flag missed a falling edge");
  AST_EF2_WRONG_EDGE: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    s_rise2 ##0 (RST_N && two_q.edge_config == EDGE_FALL && !two_q.event_flag) |=> !two_q.event_flag)
    else $error("second flag set by a rising edge in falling mode");

  // flags, interrupt requests and status copies
  AST_EF1_CLR: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    RST_N && req.wr && req.addr == OFF_ONE && !req.wdata[B_EF] && !ev1 |=> !one_q.event_flag)
    else $error("first flag not cleared by zero write");
  AST_EF2_HOLD: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    RST_N && two_q.event_flag && !(req.wr && req.addr == OFF_TWO) |=> two_q.event_flag)
    else $error("second flag dropped without write");
  AST_IRQ2: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    RST_N && two_q.event_flag && two_q.irq_enable |=> IRQ2)
    else $error("second irq missing");
  AST_IRQ1_MASK: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    RST_N && !one_q.irq_enable |=> !IRQ1)
    else $error("first irq not masked");
  AST_MIRROR2: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    RST_N |=> two_q.output_copy == $past(s2_q[1]))
    else $error("second output copy stale");

  // control outputs to the analogue side, pads and timers
  AST_ON1: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    RST_N && one_q.edge_config == EDGE_OFF |=> !CMP1_ON)
    else $error("first comparator on while disabled");
  AST_ON2: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    RST_N && two_q.edge_config != EDGE_OFF |=> CMP2_ON)
    else $error("second comparator off while configured");
  AST_SCHMITT_ON: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    RST_N && one_q.mid_bit && SW_CLOSED |=> SCHMITT_ACTIVE)
    else $error("schmitt enable not applied with switch closed");
  AST_SCHMITT_OFF: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    RST_N && !SW_CLOSED |=> !SCHMITT_ACTIVE)
    else $error("schmitt enable applied with switch open");
  AST_FAST: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    RST_N |=> FAST_MODE == $past(two_q.mid_bit))
    else $error("speed output does not follow speed bit");
  AST_INSEL: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    RST_N |=> INSEL_OUT == $past(route_q.reference_input_select))
    else $error("reference selection output wrong");
  AST_REF_CONNECT: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    RST_N |=> REF_TO_CMP1 == $past(route_q.reference_connect))
    else $error("reference connect output wrong");
  AST_WINDOW: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    RST_N |=> WINDOW_MODE == $past(route_q.window_enable))
    else $error("window mode output wrong");
  AST_REF_OUT: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    RST_N |=> REF_OUT_EN == $past(route_q.reference_output_enable))
    else $error("reference output enable wrong");
  AST_IDR_G8: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    RST_N |=> IDR_G8 == ($past(PIN_G8) & ~$past(intrig_q.hi_off)))
    else $error("group 8 input data wrong");
  AST_IDR_G2: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    RST_N |=> IDR_G2 == ($past(PIN_G2) & ~$past(intrig_q.lo_off)))
    else $error("group 2 input data wrong");
  AST_IDR_G5: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    RST_N |=> IDR_G5 == ($past(PIN_G5) & ~$past(outtrig_q.hi_off)))
    else $error("group 5 input data wrong");
  AST_IDR_G3: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    RST_N |=> IDR_G3 == ($past(PIN_G3) & ~$past(outtrig_q.lo_off)))
    else $error("group 3 input data wrong");
  AST_ROUTE_T2: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    RST_N && route_q.output_route_select == ROUTE_T2_CAP2 |=> T2_CAP2 == $past(s2_q[1]))
    else $error("timer 2 capture not fed by comparator");
  AST_ROUTE_T3: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    RST_N && route_q.output_route_select == ROUTE_T3_CAP2 |=> T3_CAP2 == $past(s2_q[1]))
    else $error("timer 3 capture not cut from pin");
  AST_PIN_BRK: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    RST_N && route_q.output_route_select != ROUTE_T1_BRK |=> T1_BRK == $past(TIM_PIN_BRK_T1))
    else $error("unrouted break input lost its pin");
  AST_ROUTE_CLR: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    RST_N && route_q.output_route_select == ROUTE_T1_CLR |=> T1_CLR == $past(s2_q[1]))
    else $error("clear input not fed by comparator");
  AST_CLR_OFF: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    RST_N && route_q.output_route_select != ROUTE_T1_CLR |=> !T1_CLR)
    else $error("clear input driven while not routed");

  // read port: data only in the cycle after the strobe
  AST_RDATA_IDLE: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    RST_N && !req.rd |=> RDATA == RD_UNMAPPED)
    else $error("read data not idle without strobe");
  AST_RDATA_ONE: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    RST_N && req.rd && req.addr == OFF_ONE |=> RDATA == $past(one_q))
    else $error("first register read back wrong");
endmodule
`default_nettype wire

/* File: cmp_ctrl_pkg.sv */
// package for the dual comparator control block: register offsets, fields, resets
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package cmp_ctrl_pkg;
  localparam int ADDR_W = 3;
  localparam logic [2:0] OFF_ONE = 3'h0;
  localparam logic [2:0] OFF_TWO = 3'h1;
  localparam logic [2:0] OFF_ROUTE = 3'h2;
  localparam logic [2:0] OFF_INTRIG = 3'h3;
  localparam logic [2:0] OFF_OUTTRIG = 3'h4;
  localparam logic [7:0] RST_ONE = 8'h00;
  localparam logic [7:0] RST_TWO = 8'h00;
  localparam logic [7:0] RST_ROUTE = 8'hc0;
  localparam logic [7:0] RST_INTRIG = 8'h00;
  localparam logic [7:0] RST_OUTTRIG = 8'h00;
  localparam int B_IE = 5;
  localparam int B_EF = 4;
  localparam int B_OUT = 3;
  localparam int B_MID = 2;
  localparam int B_EDGE = 0;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  typedef enum logic [1:0] {
    EDGE_OFF = 2'b00,
    EDGE_FALL = 2'b01,
    EDGE_RISE = 2'b10,
    EDGE_BOTH = 2'b11
  } edge_mode_t;

  typedef enum logic [1:0] {
    ROUTE_T2_CAP2 = 2'b00,
    ROUTE_T3_CAP2 = 2'b01,
    ROUTE_T1_BRK = 2'b10,
    ROUTE_T1_CLR = 2'b11
  } route_t;

  // control/status register layout, shared by both comparators
  typedef struct packed {
    logic [1:0] rsvd;
    logic irq_enable;
    logic event_flag;
    logic output_copy;
    logic mid_bit;
    edge_mode_t edge_config;
  } cmp_csr_t;

  typedef struct packed {
    route_t output_route_select;
    logic [2:0] reference_input_select;
    logic reference_connect;
    logic window_enable;
    logic reference_output_enable;
  } route_ref_t;

  typedef struct packed {
    logic [1:0] rsvd;
    logic [2:0] hi_off;
    logic [2:0] lo_off;
  } trig_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;
endpackage
`default_nettype wire

/* File: cmp_far.sv */
// far-side model: two analogue comparator outputs that follow a wanted level
// assumes the bench sets the wanted levels; outputs settle asynchronously to the clock
`timescale 1ns/100ps
`default_nettype none
module cmp_far (
  input wire logic want1,
  input wire logic want2,
  output wire logic CMP1_RAW,
  output wire logic CMP2_RAW
);
  ////////////////////////////////////////////////////////////////////////////////
  // a settling delay keeps each transition away from the sampling edge
  assign #3 CMP1_RAW = want1;
  assign #3 CMP2_RAW = want2;
endmodule
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the dual comparator control block
// assumes cmp_ctrl_pkg, cmp_ctrl and the cmp_far comparator model
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import cmp_ctrl_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, sw = 1'b0;
  logic want1 = 1'b0, want2 = 1'b0, ie, fl;
  logic [1:0] m, rt;
  logic [2:0] addr = 3'h0, p8 = 3'h0, p2 = 3'h0, p5 = 3'h0, p3 = 3'h0, tp = 3'h0;
  logic [7:0] wdata = 8'h00, rdata;
  logic [31:0] rv;
  logic cmp1_raw, cmp2_raw, irq1, irq2, on1, on2, sch, fast, t2, t3, brk, clr, ref1, wnd, refo;
  logic [2:0] insel, i8, i2, i5, i3;
  int mismatches = 0, check_count = 0, seed = 32'h6ff9f676;
  // register model, indexed by register offset
  int mreg [8] = '{0, 0, 'hc0, 0, 0, 0, 0, 0};

  always #5 clk = ~clk;

  cmp_far i_far (.want1(want1), .want2(want2), .CMP1_RAW(cmp1_raw), .CMP2_RAW(cmp2_raw));

  cmp_ctrl i_dut (.REF_CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .CMP1_RAW(cmp1_raw), .CMP2_RAW(cmp2_raw), .SW_CLOSED(sw), .PIN_G8(p8),
    .PIN_G2(p2), .PIN_G5(p5), .PIN_G3(p3), .TIM_PIN_CAP2_T2(tp[0]), .TIM_PIN_CAP2_T3(tp[1]),
    .TIM_PIN_BRK_T1(tp[2]), .IRQ1(irq1), .IRQ2(irq2), .CMP1_ON(on1), .CMP2_ON(on2),
    .SCHMITT_ACTIVE(sch), .FAST_MODE(fast), .REF_TO_CMP1(ref1), .WINDOW_MODE(wnd),
    .REF_OUT_EN(refo), .INSEL_OUT(insel), .IDR_G8(i8), .IDR_G2(i2), .IDR_G5(i5), .IDR_G3(i3),
    .T2_CAP2(t2), .T3_CAP2(t3), .T1_BRK(brk), .T1_CLR(clr));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  // reserved upper bits are written as zero by the callers, except the 8'hff write to unmapped offset 5
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    if (a == 3'h2) mreg[a] = d;
    else if (a inside {3'h3, 3'h4}) mreg[a] = d & 8'h3f;
  endtask

  task automatic rd_reg(input logic [2:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata", mreg[a][7:0], rdata);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 8; a++) rd_reg(a[2:0]);
    wr_reg(3'h5, 8'hff);
    rd_reg(3'h5);
    // every edge mode on both comparators, with enable and mid bit on and off
    for (int c = 0; c < 2; c++) begin
      for (int k = 0; k < 8; k++) begin
        ie = k[2];
        m = k[1:0];
        sw <= 1'($random(seed));
        // writing one to the flag and the output copy must change nothing
        wr_reg(c[2:0], {2'b00, ie, 1'b1, 1'b1, ie, m});
        for (int lv = 1; lv >= 0; lv--) begin
          if (c == 0) want1 <= lv[0];
          else want2 <= lv[0];
          tick(6);
          fl = lv[0] ? m[1] : m[0];
          mreg[c] = {2'b00, ie, fl, lv[0], ie, m};
          rd_reg(c[2:0]);
          chk("irq_on_mid", {5'h0, ie & fl, m != 2'b00, (c == 1) ? ie : ie & sw},
            (c == 1) ? {5'h0, irq2, on2, fast} : {5'h0, irq1, on1, sch}
            );
          wr_reg(c[2:0], {2'b00, ie, 1'b0, 1'b0, ie, m});
        end
      end
    end
    // every route, random reference selection, trigger masks and pad levels
    for (int k = 0; k < 8; k++) begin
      rt = k[1:0];
      rv = $random(seed);
      wr_reg(3'h2, {rt, rv[5:0]});
      wr_reg(3'h3, {2'b00, rv[11:6]});
      wr_reg(3'h4, {2'b00, rv[17:12]});
      rv = $random(seed);
      {p8, p2, p5, p3, tp} <= rv[14:0];
      want2 <= rv[15];
      tick(6);
      for (int a = 2; a < 5; a++) rd_reg(a[2:0]);
      chk("ctrl", {2'b00, mreg[2][5:0]},
        {2'b00, insel, ref1, wnd, refo});
      chk("idr_g8_g2", {2'b00, p8 & ~mreg[3][5:3], p2 & ~mreg[3][2:0]},
        {2'b00, i8, i2});
      chk("idr_g5_g3", {2'b00, p5 & ~mreg[4][5:3], p3 & ~mreg[4][2:0]},
        {2'b00, i5, i3});
      chk("timers", {4'h0, (rt == 2'd0) ? want2 : tp[0], (rt == 2'd1) ? want2 : tp[1],
        (rt == 2'd2) ? want2 : tp[2], (rt == 2'd3) & want2},
        {4'h0, t2, t3, brk, clr});
    end
    summarize();
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    summarize();
  end
endmodule
`default_nettype wire
